// ===== fdx_cfg.svh
// offsets, reset values and field positions of the transfer execution unit
`ifndef FDX_CFG_SVH
`define FDX_CFG_SVH
`define FDX_OFS_RF_LAST 8'h7C
`define FDX_OFS_FLAGS 8'h80
`define FDX_OFS_SP 8'h84
`define FDX_OFS_STATUS 8'h88
`define FDX_RST_FLAGS 8'h00
`define FDX_RST_SP 16'h00FF
`define FDX_RF_PTR_BASE 5'h1A
`define FDX_STATUS_BUSY 0
`define FDX_STATUS_SLEEP 1
`endif

// ===== fdx_pkg.sv
// types of the transfer execution unit
package fdx_pkg;
  typedef enum logic [4:0] {
    FDX_OP_NOP = 5'h00, FDX_OP_FSET = 5'h01, FDX_OP_FCLR = 5'h02,
    FDX_OP_MOV = 5'h03, FDX_OP_WORD_PAIR_COPY = 5'h04, FDX_OP_LDI = 5'h05,
    FDX_OP_IN = 5'h06, FDX_OP_OUT = 5'h07, FDX_OP_LDIND = 5'h08,
    FDX_OP_STIND = 5'h09, FDX_OP_LDDIR = 5'h0A, FDX_OP_STDIR = 5'h0B,
    FDX_OP_LPM = 5'h0C, FDX_OP_PUSH = 5'h0D, FDX_OP_POP = 5'h0E,
    FDX_OP_SLEEP = 5'h0F, FDX_OP_WDR = 5'h10, FDX_OP_BRK = 5'h11
  } fdx_op_t;
  typedef enum logic [1:0] {
    FDX_PTR_X = 2'h0, FDX_PTR_Y = 2'h1, FDX_PTR_Z = 2'h2
  } fdx_ptr_t;
  typedef enum logic [1:0] {
    FDX_AM_PLAIN = 2'h0, FDX_AM_POSTINC = 2'h1,
    FDX_AM_PREDEC = 2'h2, FDX_AM_DISP = 2'h3
  } fdx_am_t;
  typedef enum logic [2:0] {
    FDX_ST_IDLE = 3'b001, FDX_ST_MEM = 3'b010, FDX_ST_PWAIT = 3'b100
  } fdx_state_t;
  typedef struct packed {
    fdx_op_t op;
    logic [4:0] rd;
    logic [4:0] rr;
    fdx_ptr_t ptr;
    fdx_am_t am;
    logic [5:0] disp;
    logic [15:0] k16;
    logic [7:0] imm8;
    logic [5:0] io;
    logic [2:0] fbit;
    logic lpm_implicit;
  } fdx_ins_t;
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic we;
    logic re;
  } fdx_dm_t;
  typedef struct packed {
    fdx_state_t st;
    logic [31:0][7:0] rf;
    logic [7:0] flags;
    logic [15:0] sp;
    fdx_ins_t ins;
    fdx_dm_t dm;
    logic [15:0] pm_addr;
    logic pm_re;
    logic [5:0] io_addr;
    logic [7:0] io_wdata;
    logic io_we;
    logic sleep;
    logic watchdog_restart;
    logic brk;
    logic retire;
    logic slept;
    logic ack;
    logic [31:0] rdata;
  } fdx_st_t;
endpackage

// ===== fdx_exec.sv
// execution of flag, data transfer and control instructions
`include "fdx_cfg.svh"

// What this block does
// - set or clear half-carry or transfer flag alone, in one clock.
// - set or clear carry, negative, zero, sign, overflow flag alone, one clock.
// - post-increment load reads byte at pointer, then bumps pointer; two clocks.
// - pre-decrement load lowers pointer first, then reads new address; two clocks.
// - displacement load reads Y or Z pointer plus offset (X pointer alone), pointer kept; two clocks.
// - post-increment store writes at pointer, then bumps pointer; two clocks.
// - pre-decrement store lowers pointer, then writes new address; two clocks.
// - displacement store writes at Y or Z pointer plus offset (X pointer alone), pointer kept; two clocks.
// - direct load reads the address in the instruction; two clocks, flags kept.
// - direct store writes the address in the instruction; two clocks.
// - program read via third pointer in three clocks, into reg_zero by default.
// - push puts the source register on the stack in two clocks.
// - pop fills the destination from the stack in two clocks.
// - sleep takes one clock and signals the sleep logic.
// - watchdog_restart takes one clock and pulses the watchdog restart.
// - break only informs debug logic; retires in one clock.
module fdx_exec
  import fdx_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ins_valid,
  input wire fdx_ins_t i_ins,
  output logic o_ins_ready,
  output logic o_retire,
  output fdx_dm_t o_dm,
  input wire logic [7:0] i_dm_rdata,
  output logic [15:0] o_pm_addr,
  output logic o_pm_re,
  input wire logic [7:0] i_pm_rdata,
  output logic [5:0] o_io_raddr,
  input wire logic [7:0] i_io_rdata,
  output logic [5:0] o_io_waddr,
  output logic [7:0] o_io_wdata,
  output logic o_io_we,
  output logic o_sleep,
  output logic o_wdr,
  output logic o_break,
  output logic [7:0] o_flags,
  input wire logic [7:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest
);

  fdx_st_t s_q;
  fdx_st_t s_d;
  logic bus_req;
  logic accept;

  function automatic logic [4:0] ptr_lo(input fdx_ptr_t p);
    ptr_lo = 5'(`FDX_RF_PTR_BASE + {2'h0, p, 1'b0});
  endfunction

  assign bus_req = i_avs_read | i_avs_write;
  // software access wins over issue so a bus cycle never starves
  assign o_ins_ready = (s_q.st == FDX_ST_IDLE) && !bus_req;
  assign accept = o_ins_ready && i_ins_valid;
  assign o_avs_waitrequest = bus_req && !s_q.ack;
  assign o_avs_readdata = s_q.rdata;
  assign o_retire = s_q.retire;
  assign o_dm = s_q.dm;
  assign o_pm_addr = s_q.pm_addr;
  assign o_pm_re = s_q.pm_re;
  // port read address follows the offered instruction, data taken same edge
  assign o_io_raddr = i_ins.io;
  assign o_io_waddr = s_q.io_addr;
  assign o_io_wdata = s_q.io_wdata;
  assign o_io_we = s_q.io_we;
  assign o_sleep = s_q.sleep;
  assign o_wdr = s_q.watchdog_restart;
  assign o_break = s_q.brk;
  assign o_flags = s_q.flags;

  always_comb begin
    logic [4:0] lo;
    logic [4:0] dst;
    logic [15:0] ptr;
    logic [15:0] ea;
    logic [15:0] pinc;
    lo = 5'h00;
    dst = 5'h00;
    ptr = 16'h0000;
    ea = 16'h0000;
    pinc = 16'h0000;
    s_d = s_q;
    s_d.retire = 1'b0;
    s_d.io_we = 1'b0;
    s_d.sleep = 1'b0;
    s_d.watchdog_restart = 1'b0;
    s_d.brk = 1'b0;
    s_d.ack = 1'b0;
    s_d.dm.we = 1'b0;
    s_d.dm.re = 1'b0;
    s_d.pm_re = 1'b0;
    if (s_q.st == FDX_ST_IDLE && bus_req && !s_q.ack) begin
      s_d.ack = 1'b1;
      s_d.rdata = 32'h0000_0000;
      if (i_avs_address <= `FDX_OFS_RF_LAST) begin
        s_d.rdata[7:0] = s_q.rf[i_avs_address[6:2]];
      end else if (i_avs_address == `FDX_OFS_FLAGS) begin
        s_d.rdata[7:0] = s_q.flags;
      end else if (i_avs_address == `FDX_OFS_SP) begin
        s_d.rdata[15:0] = s_q.sp;
      end else if (i_avs_address == `FDX_OFS_STATUS) begin
        s_d.rdata[`FDX_STATUS_SLEEP] = s_q.slept;
      end
    end
    // writes land only at the edge that ends the cycle with waitrequest low
    if (s_q.ack && i_avs_write) begin
      if (i_avs_address <= `FDX_OFS_RF_LAST) begin
        if (i_avs_byteenable[0]) begin
          s_d.rf[i_avs_address[6:2]] = i_avs_writedata[7:0];
        end
      end else if (i_avs_address == `FDX_OFS_FLAGS) begin
        if (i_avs_byteenable[0]) begin
          s_d.flags = i_avs_writedata[7:0];
        end
      end else if (i_avs_address == `FDX_OFS_SP) begin
        if (i_avs_byteenable[0]) begin
          s_d.sp[7:0] = i_avs_writedata[7:0];
        end
        if (i_avs_byteenable[1]) begin
          s_d.sp[15:8] = i_avs_writedata[15:8];
        end
      end else if (i_avs_address == `FDX_OFS_STATUS) begin
        if (i_avs_byteenable[0] && i_avs_writedata[`FDX_STATUS_SLEEP]) begin
          s_d.slept = 1'b0;
        end
      end
    end
    lo = ptr_lo(s_q.ins.ptr);
    ptr = {s_q.rf[lo + 5'h01], s_q.rf[lo]};
    pinc = ptr + 16'h0001;
    case (s_q.st)
      FDX_ST_IDLE: begin
        if (accept) begin
          s_d.ins = i_ins;
          lo = ptr_lo(i_ins.ptr);
          ptr = {s_q.rf[lo + 5'h01], s_q.rf[lo]};
          ea = ptr;
          s_d.retire = 1'b1;
          case (i_ins.op)
            // only the named flag bit changes
            FDX_OP_FSET: s_d.flags[i_ins.fbit] = 1'b1;
            FDX_OP_FCLR: s_d.flags[i_ins.fbit] = 1'b0;
            FDX_OP_MOV: s_d.rf[i_ins.rd] = s_q.rf[i_ins.rr];
            FDX_OP_WORD_PAIR_COPY: begin
              s_d.rf[{i_ins.rd[4:1], 1'b0}] = s_q.rf[{i_ins.rr[4:1], 1'b0}];
              s_d.rf[{i_ins.rd[4:1], 1'b1}] = s_q.rf[{i_ins.rr[4:1], 1'b1}];
            end
            FDX_OP_LDI: s_d.rf[i_ins.rd] = i_ins.imm8;
            FDX_OP_IN: s_d.rf[i_ins.rd] = i_io_rdata;
            FDX_OP_OUT: begin
              s_d.io_we = 1'b1;
              s_d.io_addr = i_ins.io;
              s_d.io_wdata = s_q.rf[i_ins.rr];
            end
            FDX_OP_LDIND, FDX_OP_STIND: begin
              // store goes to the lowered address
              if (i_ins.am == FDX_AM_PREDEC) begin
                ea = ptr - 16'h0001;
                s_d.rf[lo] = ea[7:0];
                s_d.rf[lo + 5'h01] = ea[15:8];
              end else if (i_ins.am == FDX_AM_DISP && i_ins.ptr != FDX_PTR_X) begin
                ea = ptr + {10'h000, i_ins.disp};
              end
              s_d.dm.addr = ea;
              s_d.dm.re = (i_ins.op == FDX_OP_LDIND);
              s_d.dm.we = (i_ins.op == FDX_OP_STIND);
              s_d.dm.wdata = s_q.rf[i_ins.rr];
              s_d.retire = 1'b0;
              s_d.st = FDX_ST_MEM;
            end
            FDX_OP_LDDIR, FDX_OP_STDIR: begin
              s_d.dm.addr = i_ins.k16;
              s_d.dm.re = (i_ins.op == FDX_OP_LDDIR);
              s_d.dm.we = (i_ins.op == FDX_OP_STDIR);
              s_d.dm.wdata = s_q.rf[i_ins.rr];
              s_d.retire = 1'b0;
              s_d.st = FDX_ST_MEM;
            end
            // program read always through the third pointer
            FDX_OP_LPM: begin
              s_d.ins.ptr = FDX_PTR_Z;
              s_d.pm_addr = {s_q.rf[ptr_lo(FDX_PTR_Z) + 5'h01],
                             s_q.rf[ptr_lo(FDX_PTR_Z)]};
              s_d.pm_re = 1'b1;
              s_d.retire = 1'b0;
              s_d.st = FDX_ST_MEM;
            end
            // write at stack pointer, then lower it
            FDX_OP_PUSH: begin
              s_d.dm.addr = s_q.sp;
              s_d.dm.we = 1'b1;
              s_d.dm.wdata = s_q.rf[i_ins.rr];
              s_d.sp = s_q.sp - 16'h0001;
              s_d.retire = 1'b0;
              s_d.st = FDX_ST_MEM;
            end
            FDX_OP_POP: begin
              s_d.sp = s_q.sp + 16'h0001;
              s_d.dm.addr = s_q.sp + 16'h0001;
              s_d.dm.re = 1'b1;
              s_d.retire = 1'b0;
              s_d.st = FDX_ST_MEM;
            end
            FDX_OP_SLEEP: begin
              s_d.sleep = 1'b1;
              s_d.slept = 1'b1;
            end
            FDX_OP_WDR: s_d.watchdog_restart = 1'b1;
            // only a debug pulse, no other effect
            FDX_OP_BRK: s_d.brk = 1'b1;
            default: s_d.retire = 1'b1;
          endcase
        end
      end
      FDX_ST_MEM: begin
        s_d.dm.re = 1'b0;
        s_d.dm.we = 1'b0;
        if ((s_q.ins.op == FDX_OP_LDIND || s_q.ins.op == FDX_OP_STIND)
            && s_q.ins.am == FDX_AM_POSTINC) begin
          s_d.rf[lo] = pinc[7:0];
          s_d.rf[lo + 5'h01] = pinc[15:8];
        end
        // loaded byte written last so it wins over a pointer overlap
        if (s_q.ins.op == FDX_OP_LDIND || s_q.ins.op == FDX_OP_LDDIR
            || s_q.ins.op == FDX_OP_POP) begin
          s_d.rf[s_q.ins.rd] = i_dm_rdata;
        end
        if (s_q.ins.op == FDX_OP_LPM) begin
          s_d.pm_re = 1'b1;
          s_d.st = FDX_ST_PWAIT;
        end else begin
          s_d.retire = 1'b1;
          s_d.st = FDX_ST_IDLE;
        end
      end
      FDX_ST_PWAIT: begin
        // third clock takes the byte, optional pointer bump
        dst = s_q.ins.lpm_implicit ? 5'h00 : s_q.ins.rd;
        if (s_q.ins.am == FDX_AM_POSTINC) begin
          s_d.rf[lo] = pinc[7:0];
          s_d.rf[lo + 5'h01] = pinc[15:8];
        end
        s_d.rf[dst] = i_pm_rdata;
        s_d.retire = 1'b1;
        s_d.st = FDX_ST_IDLE;
      end
      default: s_d.st = FDX_ST_IDLE;
    endcase
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      s_q <= '0;
      s_q.st <= FDX_ST_IDLE;
      s_q.flags <= `FDX_RST_FLAGS;
      s_q.sp <= `FDX_RST_SP;
    end else begin
      s_q <= s_d;
    end
  end

endmodule

// ===== fdx_mem_model.sv
// data memory, stack and program memory beside the execution unit
module fdx_mem_model
  import fdx_pkg::*;
(
  input wire logic i_clk,
  input wire fdx_dm_t i_dm,
  input wire logic [15:0] i_pm_addr,
  input wire logic i_pm_re,
  output logic [7:0] o_dm_rdata,
  output logic [7:0] o_pm_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [256];
  logic [7:0] last_q = 8'h00;
  initial for (int i = 0; i < 256; i++) mem[i] = i[7:0] ^ 8'h5A;
  // idle lines show the inverse of the last data byte read, never a stale match
  assign o_dm_rdata = i_dm.re ? mem[i_dm.addr[7:0]] : ~last_q;
  assign o_pm_rdata = i_pm_re ? i_pm_addr[7:0] ^ 8'hC3 : ~last_q;
  always @(posedge i_clk) begin
    if (i_dm.re)
      last_q <= o_dm_rdata;
    if (i_dm.we)
      mem[i_dm.addr[7:0]] <= i_dm.wdata;
  end
endmodule

// ===== fdx_exec_assertions.sv
// concurrent checks on the ports of the transfer execution unit
module fdx_exec_chk
  import fdx_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ins_valid,
  input wire fdx_ins_t i_ins,
  input wire logic o_ins_ready,
  input wire logic o_retire,
  input wire fdx_dm_t o_dm,
  input wire logic o_pm_re,
  input wire logic o_sleep,
  input wire logic o_wdr,
  input wire logic [7:0] o_flags
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  logic acc;
  logic mem_op;
  fdx_op_t op;
  assign acc = i_ins_valid && o_ins_ready;
  assign op = i_ins.op;
  assign mem_op = op inside {FDX_OP_LDIND, FDX_OP_STIND, FDX_OP_LDDIR,
    FDX_OP_STDIR, FDX_OP_PUSH, FDX_OP_POP};
  a_flag_set: assert property (
    acc && op == FDX_OP_FSET |=> o_retire &&
    o_flags == ($past(o_flags) | (8'h01 << $past(i_ins.fbit))))
    else $error("flag set wrong");
  a_flag_clear: assert property (
    acc && op == FDX_OP_FCLR |=> o_retire &&
    o_flags == ($past(o_flags) & ~(8'h01 << $past(i_ins.fbit))))
    else $error("flag clear wrong");
  a_mem_two_clocks: assert property (
    acc && mem_op |=> !o_retire ##1 o_retire)
    else $error("memory op not two clocks");
  a_mem_flags_kept: assert property (
    acc && mem_op |=> $stable(o_flags) [*2])
    else $error("memory op changed flags");
  a_prog_three_clocks: assert property (
    acc && op == FDX_OP_LPM |=> o_pm_re [*2] ##1 o_retire)
    else $error("program read not three clocks");
  a_one_clock_op: assert property (
    acc && op inside {FDX_OP_MOV, FDX_OP_WORD_PAIR_COPY, FDX_OP_LDI, FDX_OP_IN,
    FDX_OP_OUT, FDX_OP_NOP} |=> o_retire && $stable(o_flags))
    else $error("move op not one clock");
  a_sleep_pulse: assert property (
    acc && op == FDX_OP_SLEEP |=> o_sleep && o_retire ##1 !o_sleep)
    else $error("sleep pulse wrong");
  a_wdr_pulse: assert property (
    acc && op == FDX_OP_WDR |=> o_wdr && o_retire && $stable(o_flags))
    else $error("watchdog restart pulse wrong");
  a_direct_store: assert property (
    acc && op == FDX_OP_STDIR |=> o_dm.we && o_dm.addr == $past(i_ins.k16))
    else $error("direct store address wrong");
endmodule

bind fdx_exec fdx_exec_chk i_fdx_exec_chk (
  .i_clk, .i_rst, .i_ins_valid, .i_ins, .o_ins_ready, .o_retire,
  .o_dm, .o_pm_re, .o_sleep, .o_wdr, .o_flags
);

// ===== fdx_exec_tb.sv
// self-checking bench of the transfer execution unit
module fdx_exec_tb
  import fdx_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [4:0] op, rd, rr;
    logic [1:0] p, am;
    logic [7:0] k;
    logic [1:0] c;
    logic [7:0] a, v;
  } fdx_row_t;
  localparam int NR = 23;
  // op rd rr ptr mode k cycles readback-address expected
  localparam fdx_row_t RW [NR] = '{
    '{5'h05,5'h10,5'h00,2'h0,2'h0,8'h3C,2'h1,8'h40,8'h3C},
    '{5'h03,5'h11,5'h10,2'h0,2'h0,8'h00,2'h1,8'h44,8'h3C},
    '{5'h06,5'h0B,5'h00,2'h0,2'h0,8'h05,2'h1,8'h2C,8'h85},
    '{5'h07,5'h00,5'h10,2'h0,2'h0,8'h07,2'h1,8'h40,8'h3C},
    '{5'h08,5'h02,5'h00,2'h0,2'h1,8'h00,2'h2,8'h08,8'h4A},
    '{5'h00,5'h00,5'h00,2'h0,2'h0,8'h00,2'h1,8'h68,8'h11},
    '{5'h08,5'h03,5'h00,2'h1,2'h2,8'h00,2'h2,8'h0C,8'h45},
    '{5'h00,5'h00,5'h00,2'h0,2'h0,8'h00,2'h1,8'h70,8'h1F},
    '{5'h08,5'h04,5'h00,2'h2,2'h3,8'h05,2'h2,8'h10,8'h6F},
    '{5'h09,5'h00,5'h10,2'h0,2'h1,8'h00,2'h2,8'h68,8'h12},
    '{5'h0A,5'h05,5'h00,2'h0,2'h0,8'h11,2'h2,8'h14,8'h3C},
    '{5'h09,5'h00,5'h11,2'h1,2'h2,8'h00,2'h2,8'h70,8'h1E},
    '{5'h08,5'h06,5'h00,2'h1,2'h0,8'h00,2'h2,8'h18,8'h3C},
    '{5'h09,5'h00,5'h02,2'h2,2'h3,8'h02,2'h2,8'h78,8'h30},
    '{5'h08,5'h08,5'h00,2'h2,2'h3,8'h02,2'h2,8'h20,8'h4A},
    '{5'h0B,5'h00,5'h03,2'h0,2'h0,8'h40,2'h2,8'h78,8'h30},
    '{5'h0A,5'h07,5'h00,2'h0,2'h0,8'h40,2'h2,8'h1C,8'h45},
    '{5'h0C,5'h00,5'h00,2'h2,2'h0,8'h00,2'h3,8'h00,8'hF3},
    '{5'h0C,5'h09,5'h00,2'h2,2'h1,8'h00,2'h3,8'h24,8'hF3},
    '{5'h00,5'h00,5'h00,2'h0,2'h0,8'h00,2'h1,8'h78,8'h31},
    '{5'h0D,5'h00,5'h10,2'h0,2'h0,8'h00,2'h2,8'h84,8'hFE},
    '{5'h0E,5'h0A,5'h00,2'h0,2'h0,8'h00,2'h2,8'h28,8'h3C},
    '{5'h04,5'h0C,5'h02,2'h0,2'h0,8'h00,2'h1,8'h34,8'h45}
  };
  logic clk = 1'b0, rst = 1'b1, valid = 1'b0, rd_s = 1'b0, wr_s = 1'b0;
  logic rdy, ret, pm_re, io_we, wq;
  logic [7:0] ad = 8'h00, dm_rd, pm_rd, io_rd, io_wd, flg, fl = 8'h00;
  logic [5:0] io_ra, io_wa;
  logic [15:0] pm_a;
  logic [13:0] io_q = 14'h0000;
  logic slp, wdg, bkp;
  logic [2:0] pls = 3'h0;
  logic [31:0] wd = 32'h00000000, rdata, q;
  fdx_ins_t ins = '0, x;
  fdx_dm_t dm;
  int failures = 0, tests_run = 0;
  always #5 clk = ~clk;
  assign io_rd = {2'b10, io_ra};
  always @(posedge clk) if (io_we) io_q <= {io_wa, io_wd};
  // sticky record of the control pulses, so a missed one shows later
  always @(posedge clk) pls <= pls | {bkp, wdg, slp};
  fdx_exec i_fdx_exec (
    .i_clk(clk), .i_rst(rst), .i_ins_valid(valid), .i_ins(ins),
    .o_ins_ready(rdy), .o_retire(ret), .o_dm(dm), .i_dm_rdata(dm_rd),
    .o_pm_addr(pm_a), .o_pm_re(pm_re), .i_pm_rdata(pm_rd),
    .o_io_raddr(io_ra), .i_io_rdata(io_rd), .o_io_waddr(io_wa),
    .o_io_wdata(io_wd), .o_io_we(io_we), .o_sleep(slp), .o_wdr(wdg),
    .o_break(bkp), .o_flags(flg), .i_avs_address(ad), .i_avs_read(rd_s),
    .i_avs_write(wr_s), .i_avs_writedata(wd), .i_avs_byteenable(4'hF),
    .o_avs_readdata(rdata), .o_avs_waitrequest(wq)
  );
  fdx_mem_model i_fdx_mem_model (
    .i_clk(clk), .i_dm(dm), .i_pm_addr(pm_a), .i_pm_re(pm_re),
    .o_dm_rdata(dm_rd), .o_pm_rdata(pm_rd)
  );
  task automatic chk(input string n, input logic [31:0] s, e);
    tests_run++;
    if (s !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic av(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] r);
    @(posedge clk);
    rd_s <= !w;
    wr_s <= w;
    ad <= a;
    wd <= d;
    // values seen here are those that stood just before the edge
    do @(posedge clk); while (wq !== 1'b0);
    r = rdata;
    rd_s <= 1'b0;
    wr_s <= 1'b0;
  endtask
  task automatic ex(input fdx_ins_t i, input logic [1:0] c);
    int n;
    @(posedge clk);
    valid <= 1'b1;
    ins <= i;
    do @(posedge clk); while (rdy !== 1'b1);
    valid <= 1'b0;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ret !== 1'b1 && n < 8);
    chk("cycles", n, c);
    chk("flags", flg, fl);
  endtask
  task automatic fop(input int b);
    x = '0;
    x.op = b < 8 ? FDX_OP_FSET : FDX_OP_FCLR;
    x.fbit = b[2:0];
    fl[b % 8] = b < 8;
    ex(x, 2'h1);
  endtask
  task automatic wrap_up;
    if (failures == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    #100us;
    failures++;
    wrap_up();
  end
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    av(1'b0, 8'h84, 32'h00000000, q);
    chk("sp", q, 32'h000000FF);
    for (int p = 0; p < 3; p++) av(1'b1, 8'h68 + 8'(p * 8), 32'(16 * p + 16), q);
    // set flags one at a time, then keep them through the transfers
    for (int b = 0; b < 8; b++) fop(b);
    for (int i = 0; i < NR; i++) begin
      x = '0;
      x.op = fdx_op_t'(RW[i].op);
      x.rd = RW[i].rd;
      x.rr = RW[i].rr;
      x.ptr = fdx_ptr_t'(RW[i].p);
      x.am = fdx_am_t'(RW[i].am);
      x.disp = RW[i].k[5:0];
      x.k16 = {8'h00, RW[i].k};
      x.imm8 = RW[i].k;
      x.io = RW[i].k[5:0];
      x.lpm_implicit = RW[i].rd == 5'h00;
      ex(x, RW[i].c);
      av(1'b0, RW[i].a, 32'h00000000, q);
      chk("readback", q, {24'h000000, RW[i].v});
    end
    chk("io_out", io_q, {6'h07, 8'h3C});
    for (int b = 8; b < 16; b++) fop(b);
    x = '0;
    chk("no_pulse", pls, 3'h0);
    x.op = FDX_OP_SLEEP;
    ex(x, 2'h1);
    chk("sleep_pulse", pls | {bkp, wdg, slp}, 3'h1);
    x.op = FDX_OP_WDR;
    ex(x, 2'h1);
    chk("wdr_pulse", pls | {bkp, wdg, slp}, 3'h3);
    x.op = FDX_OP_BRK;
    ex(x, 2'h1);
    chk("brk_pulse", pls | {bkp, wdg, slp}, 3'h7);
    av(1'b0, 8'h88, 32'h00000000, q);
    chk("sleep_seen", q[1], 1'b1);
    av(1'b1, 8'h88, 32'h00000002, q);
    av(1'b0, 8'h88, 32'h00000000, q);
    chk("sleep_clr", q[1], 1'b0);
    av(1'b1, 8'hFC, 32'hFFFFFFFF, q);
    av(1'b0, 8'hFC, 32'h00000000, q);
    chk("unmapped", q, 32'h00000000);
    // second reset in mid-run must restore stack pointer and registers
    @(posedge clk);
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    av(1'b0, 8'h40, 32'h00000000, q);
    chk("reg_reset", q, 32'h00000000);
    av(1'b0, 8'h84, 32'h00000000, q);
    chk("sp_reset", q, 32'h000000FF);
    wrap_up();
  end
endmodule
